// [rtl/port_pin_pkg.sv]
// Constants and types for the port pin control block.
// Assumes one 20 MHz clock and a plain register port with 8-bit data.
package port_pin_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CMD = 5'h01;
  localparam logic [4:0] OFS_ANALOG_SEL = 5'h02;
  localparam logic [4:0] OFS_ADC_CH = 5'h03;
  localparam logic [4:0] OFS_EDGE_SEL = 5'h04;
  localparam logic [4:0] OFS_IRQIO_DIR = 5'h05;
  localparam logic [4:0] OFS_BIDIR_DIR = 5'h06;
  localparam logic [4:0] OFS_IRQIO_DATA = 5'h07;
  localparam logic [4:0] OFS_BIDIR_DATA = 5'h08;
  localparam logic [4:0] OFS_OD_DATA = 5'h09;
  localparam logic [4:0] OFS_SHARED_IN = 5'h0A;
  localparam logic [4:0] OFS_IRQIO_IN = 5'h0B;
  localparam logic [4:0] OFS_BIDIR_IN = 5'h0C;
  localparam logic [4:0] OFS_STATE = 5'h0D;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h0E;
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h0F;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h10;

  // Field positions
  localparam int CMD_STOP_BIT = 0;
  localparam int CMD_ADC_START_BIT = 2;
  localparam int EDGE_A_BIT = 0;
  localparam int EDGE_B_BIT = 1;
  localparam int IRQ_A_BIT = 0;
  localparam int IRQ_B_BIT = 1;
  localparam int IRQ_ADC_BIT = 2;
  localparam int ST_STOPPED_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_HOLDGATE_BIT = 2;
  localparam int ST_HOLDPIN_BIT = 3;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [5:0] ANALOG_SEL_RST = 6'h00;
  localparam logic [2:0] ADC_CH_RST = 3'h0;
  localparam logic [1:0] EDGE_SEL_RST = 2'h0;
  localparam logic [3:0] IRQIO_DIR_RST = 4'h0;
  localparam logic [7:0] BIDIR_DIR_RST = 8'h00;
  localparam logic [3:0] IRQIO_DATA_RST = 4'h0;
  localparam logic [7:0] BIDIR_DATA_RST = 8'h00;
  localparam logic [3:0] OD_DATA_RST = 4'hF;
  localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;

  // Control register layout, high bit first
  typedef struct packed {
    logic extIrqBEnable;
    logic extIrqAEnable;
    logic globalIrqEnable;
    logic holdEnableFlag;
  } ctrl_t;

  // Drive of the port pins toward the pads
  typedef struct packed {
    logic [3:0] odOe;
    logic [3:0] irqIoOut;
    logic [3:0] irqIoOe;
    logic [7:0] bidirOut;
    logic [7:0] bidirOe;
  } pin_drive_t;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b01,
    MODE_STOP = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    ADC_IDLE = 2'b01,
    ADC_BUSY = 2'b10
  } adc_state_t;

endpackage

// [rtl/port_pin_control.sv]
// Pin-level port control: hold pin, clock stop, analog-shared inputs,
// open-drain outputs, interrupt-shared and plain bidirectional ports.
// Assumes pins arrive asynchronous to clk; the A/D core answers on clk.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sync2

// Notes on behaviour
// RULE_01: Hold enabled and hold pin low: block both PLL inputs, float error output.
// RULE_02: Software enters clock stop: set hold enable, hold pin low, issue stop.
// RULE_03: Clock stop ends when the hold pin goes high.
// RULE_04: Per-bit select of six shared pins as general input or analog input.
// RULE_05: Channel register chooses which analog pin is converted.
// RULE_06: Command bit 2 starts a conversion; done flag sets when it finishes.
// RULE_07: Reading a pin set for analog use returns low.
// RULE_08: Analog-shared inputs disabled in clock stop; reset to general input.
// RULE_09: In clock stop the open-drain transistors turn off.
// RULE_10: At reset open-drain ports are outputs with transistors off.
// RULE_11: Interrupt pins act as interrupts whenever their enable flag is set.
// RULE_12: Interrupt-shared port direction selectable bit by bit.
// RULE_13: Software sets per-pin interrupt enable and makes the pin an input.
// RULE_14: External interrupts serviced only with global interrupt enable set.
// RULE_15: Edge select: bit 1 for second interrupt, bit 0 for first.
// RULE_16: Interrupt-shared pins float and disable input in stop; reset to input.
// RULE_17: Eight bidirectional pins: settable direction, float in stop, reset to input.
// RULE_18: Synchronous edge detector raises one pending request per selected edge.
module port_pin_control (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [port_pin_pkg::ADDR_W-1:0] regAddr,
  input wire logic [port_pin_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [port_pin_pkg::DATA_W-1:0] regRdata,
  output logic irq,
  input wire logic holdPin,
  input wire logic pllFmIn,
  input wire logic pllAmIn,
  output logic pllFmGated,
  output logic pllAmGated,
  input wire logic pllErrIn,
  output logic pllErrOut,
  output logic pllErrOe,
  input wire logic [5:0] analogPinIn,
  output logic [5:0] analogSelect,
  output logic [2:0] adcChannel,
  output logic adcStart,
  input wire logic adcDone,
  output logic [3:0] openDrainOut,
  output logic [3:0] openDrainOe,
  input wire logic [3:0] irqIoIn,
  output logic [3:0] irqIoOut,
  output logic [3:0] irqIoOe,
  input wire logic [7:0] bidirIn,
  output logic [7:0] bidirOut,
  output logic [7:0] bidirOe,
  output logic clockStopped
);
  import port_pin_pkg::*;

  ctrl_t ctrl_r;
  mode_t mode_r;
  adc_state_t adcState_r;
  pin_drive_t drive;
  logic [5:0] analogSel_r;
  logic [2:0] adcCh_r;
  logic [1:0] edgeSel_r;
  logic [3:0] irqIoDir_r;
  logic [7:0] bidirDir_r;
  logic [3:0] irqIoData_r;
  logic [7:0] bidirData_r;
  logic [3:0] odData_r;
  logic [2:0] irqStatus_r;
  logic [2:0] irqEnable_r;
  logic [2:0] irqSet;
  logic [2:0] irqClr;
  logic [DATA_W-1:0] rdata_nxt;
  logic doneFlag_r;
  logic adcStart_r;
  logic holdSync;
  logic [5:0] analogSync;
  logic [3:0] irqIoSync;
  logic [7:0] bidirSync;
  logic [1:0] irqPinPrev_r;
  logic [1:0] edgeHit;
  logic stopped;
  logic holdGate;
  logic [5:0] sharedRead;
  logic [3:0] irqIoRead;
  logic [7:0] bidirRead;
  logic wrCmd;

  sync2 #(.W(1)) uHoldSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(holdPin),
    .q(holdSync)
  );

  sync2 #(.W(6)) uAnalogSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(analogPinIn),
    .q(analogSync)
  );

  sync2 #(.W(4)) uIrqIoSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(irqIoIn),
    .q(irqIoSync)
  );

  sync2 #(.W(8)) uBidirSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(bidirIn),
    .q(bidirSync)
  );

  assign stopped = (mode_r == MODE_STOP);
  assign wrCmd = regWr && (regAddr == OFS_CMD);

  // PLL gating follows the hold pin through the two-flop sync; the PLL signals are fast analog-rate paths
  assign holdGate = ctrl_r.holdEnableFlag && !holdSync; // RULE_01
  assign pllFmGated = pllFmIn && !holdGate; // RULE_01
  assign pllAmGated = pllAmIn && !holdGate; // RULE_01
  assign pllErrOut = pllErrIn;
  assign pllErrOe = !holdGate; // RULE_01

  // Clock stop mode
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_r <= MODE_RUN;
    end
    else
    begin
      case (mode_r)
        MODE_RUN:
        begin
          // A stop request without the hold conditions is ignored
          if (wrCmd && regWdata[CMD_STOP_BIT] && holdGate) // RULE_02
          begin
            mode_r <= MODE_STOP;
          end
        end
        MODE_STOP:
        begin
          if (holdSync) // RULE_03
          begin
            mode_r <= MODE_RUN;
          end
        end
        default:
        begin
          mode_r <= MODE_RUN;
        end
      endcase
    end
  end

  // Control flags
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_r <= ctrl_t'(CTRL_RST);
    end
    else if (regWr && (regAddr == OFS_CTRL))
    begin
      ctrl_r <= ctrl_t'(regWdata[3:0]);
    end
  end

  // Port configuration
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      analogSel_r <= ANALOG_SEL_RST; // RULE_08
      adcCh_r <= ADC_CH_RST;
      edgeSel_r <= EDGE_SEL_RST;
      irqIoDir_r <= IRQIO_DIR_RST; // RULE_16
      bidirDir_r <= BIDIR_DIR_RST; // RULE_17
    end
    else if (regWr)
    begin
      if (regAddr == OFS_ANALOG_SEL)
      begin
        analogSel_r <= regWdata[5:0]; // RULE_04
      end
      else if (regAddr == OFS_ADC_CH)
      begin
        adcCh_r <= regWdata[2:0]; // RULE_05
      end
      else if (regAddr == OFS_EDGE_SEL)
      begin
        edgeSel_r <= regWdata[1:0]; // RULE_15
      end
      else if (regAddr == OFS_IRQIO_DIR)
      begin
        irqIoDir_r <= regWdata[3:0]; // RULE_12
      end
      else if (regAddr == OFS_BIDIR_DIR)
      begin
        bidirDir_r <= regWdata; // RULE_17
      end
    end
  end

  // Output latches; written data is kept through clock stop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqIoData_r <= IRQIO_DATA_RST;
      bidirData_r <= BIDIR_DATA_RST;
      odData_r <= OD_DATA_RST; // RULE_10
    end
    else if (regWr)
    begin
      if (regAddr == OFS_IRQIO_DATA)
      begin
        irqIoData_r <= regWdata[3:0];
      end
      else if (regAddr == OFS_BIDIR_DATA)
      begin
        bidirData_r <= regWdata;
      end
      else if (regAddr == OFS_OD_DATA)
      begin
        odData_r <= regWdata[3:0];
      end
    end
  end

  // Pad drive; a data bit of one means the open-drain transistor is off
  always_comb
  begin
    drive.odOe = ~odData_r & {4{!stopped}}; // RULE_09
    drive.irqIoOut = irqIoData_r;
    drive.irqIoOe = irqIoDir_r & {4{!stopped}}; // RULE_16
    drive.bidirOut = bidirData_r;
    drive.bidirOe = bidirDir_r & {8{!stopped}}; // RULE_17
  end

  assign openDrainOut = 4'h0;
  assign openDrainOe = drive.odOe;
  assign irqIoOut = drive.irqIoOut;
  assign irqIoOe = drive.irqIoOe;
  assign bidirOut = drive.bidirOut;
  assign bidirOe = drive.bidirOe;
  assign analogSelect = analogSel_r;
  assign adcChannel = adcCh_r;
  assign adcStart = adcStart_r;
  assign clockStopped = stopped;

  // Digital input paths; disabled inputs read low
  assign sharedRead = analogSync & ~analogSel_r & {6{!stopped}}; // RULE_07 RULE_08
  assign irqIoRead = irqIoSync & {4{!stopped}}; // RULE_16
  assign bidirRead = bidirSync & {8{!stopped}}; // RULE_17

  // Conversion sequencing toward the A/D core
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      adcState_r <= ADC_IDLE;
      adcStart_r <= 1'b0;
      doneFlag_r <= 1'b0;
    end
    else
    begin
      adcStart_r <= 1'b0;
      case (adcState_r)
        ADC_IDLE:
        begin
          if (wrCmd && regWdata[CMD_ADC_START_BIT] && !stopped) // RULE_06
          begin
            adcStart_r <= 1'b1;
            doneFlag_r <= 1'b0;
            adcState_r <= ADC_BUSY;
          end
        end
        ADC_BUSY:
        begin
          // Starts while busy are ignored so a result is never orphaned
          if (adcDone)
          begin
            doneFlag_r <= 1'b1; // RULE_06
            adcState_r <= ADC_IDLE;
          end
        end
        default:
        begin
          adcState_r <= ADC_IDLE;
        end
      endcase
    end
  end

  // Edge detection on interrupt-shared pins 0 and 1
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqPinPrev_r <= 2'b00;
    end
    else
    begin
      irqPinPrev_r <= irqIoRead[1:0]; // RULE_18
    end
  end

  // Edge select bit high picks falling, low picks rising
  assign edgeHit[0] = ctrl_r.extIrqAEnable && // RULE_11
    (edgeSel_r[EDGE_A_BIT] ? (irqPinPrev_r[0] && !irqIoRead[0])
                           : (!irqPinPrev_r[0] && irqIoRead[0])); // RULE_15 RULE_18
  assign edgeHit[1] = ctrl_r.extIrqBEnable && // RULE_11
    (edgeSel_r[EDGE_B_BIT] ? (irqPinPrev_r[1] && !irqIoRead[1])
                           : (!irqPinPrev_r[1] && irqIoRead[1])); // RULE_15 RULE_18

  always_comb
  begin
    irqSet = 3'h0;
    irqSet[IRQ_A_BIT] = edgeHit[0];
    irqSet[IRQ_B_BIT] = edgeHit[1];
    irqSet[IRQ_ADC_BIT] = (adcState_r == ADC_BUSY) && adcDone;
    irqClr = 3'h0;
    if (regWr && (regAddr == OFS_IRQ_CLEAR))
    begin
      irqClr = regWdata[2:0];
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqStatus_r <= 3'h0;
    end
    else
    begin
      irqStatus_r <= (irqStatus_r & ~irqClr) | irqSet; // RULE_18
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irqEnable_r <= IRQ_ENABLE_RST;
    end
    else if (regWr && (regAddr == OFS_IRQ_ENABLE))
    begin
      irqEnable_r <= regWdata[2:0];
    end
  end

  // Pending requests stay latched while the global enable is off
  assign irq = ctrl_r.globalIrqEnable && |(irqStatus_r & irqEnable_r); // RULE_14

  // Read decode
  always_comb
  begin
    rdata_nxt = '0;
    if (regAddr == OFS_CTRL)
    begin
      rdata_nxt[3:0] = ctrl_r;
    end
    else if (regAddr == OFS_ANALOG_SEL)
    begin
      rdata_nxt[5:0] = analogSel_r;
    end
    else if (regAddr == OFS_ADC_CH)
    begin
      rdata_nxt[2:0] = adcCh_r;
    end
    else if (regAddr == OFS_EDGE_SEL)
    begin
      rdata_nxt[1:0] = edgeSel_r;
    end
    else if (regAddr == OFS_IRQIO_DIR)
    begin
      rdata_nxt[3:0] = irqIoDir_r;
    end
    else if (regAddr == OFS_BIDIR_DIR)
    begin
      rdata_nxt = bidirDir_r;
    end
    else if (regAddr == OFS_IRQIO_DATA)
    begin
      rdata_nxt[3:0] = irqIoData_r;
    end
    else if (regAddr == OFS_BIDIR_DATA)
    begin
      rdata_nxt = bidirData_r;
    end
    else if (regAddr == OFS_OD_DATA)
    begin
      rdata_nxt[3:0] = odData_r;
    end
    else if (regAddr == OFS_SHARED_IN)
    begin
      rdata_nxt[5:0] = sharedRead; // RULE_07
    end
    else if (regAddr == OFS_IRQIO_IN)
    begin
      rdata_nxt[3:0] = irqIoRead;
    end
    else if (regAddr == OFS_BIDIR_IN)
    begin
      rdata_nxt = bidirRead;
    end
    else if (regAddr == OFS_STATE)
    begin
      rdata_nxt[ST_STOPPED_BIT] = stopped;
      rdata_nxt[ST_DONE_BIT] = doneFlag_r;
      rdata_nxt[ST_HOLDGATE_BIT] = holdGate;
      rdata_nxt[ST_HOLDPIN_BIT] = holdSync;
    end
    else if (regAddr == OFS_IRQ_STATUS)
    begin
      rdata_nxt[2:0] = irqStatus_r;
    end
    else if (regAddr == OFS_IRQ_ENABLE)
    begin
      rdata_nxt[2:0] = irqEnable_r;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      regRdata <= '0;
    end
    else if (regRd)
    begin
      regRdata <= rdata_nxt;
    end
    else
    begin
      regRdata <= '0;
    end
  end

endmodule // port_pin_control

// [test/port_pin_monitor.sv]
// Concurrent checks on the port pin control block.
// Assumes only the block's top ports; bound to every instance.
`timescale 1ns/1ps
module port_pin_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic holdPin,
  input wire logic pllFmIn,
  input wire logic pllAmIn,
  input wire logic pllFmGated,
  input wire logic pllAmGated,
  input wire logic pllErrIn,
  input wire logic pllErrOut,
  input wire logic pllErrOe,
  input wire logic [5:0] analogSelect,
  input wire logic adcStart,
  input wire logic [3:0] openDrainOe,
  input wire logic [3:0] irqIoOe,
  input wire logic [7:0] bidirOe,
  input wire logic clockStopped
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_pll_blocked: assert property (!pllErrOe |-> !pllFmGated && !pllAmGated)
    else $error("PLL inputs pass while error output floats");
  a_pll_passes: assert property (pllErrOe |-> pllFmGated == pllFmIn && pllAmGated == pllAmIn && pllErrOut == pllErrIn)
    else $error("PLL path does not follow its inputs");
  a_od_stop_off: assert property (clockStopped |-> openDrainOe == 4'h0)
    else $error("open-drain transistor on in clock stop");
  a_io_stop_float: assert property (clockStopped |-> irqIoOe == 4'h0 && bidirOe == 8'h00)
    else $error("port driven in clock stop");
  a_stop_exit: assert property ((clockStopped && holdPin) ##1 holdPin [*5] |=> !clockStopped)
    else $error("clock stop kept with hold pin high");
  a_start_single: assert property (adcStart |=> !adcStart)
    else $error("conversion start longer than one cycle");
  a_no_start_stopped: assert property ($past(clockStopped) && clockStopped |-> !adcStart)
    else $error("conversion started in clock stop");
  a_reset_pins: assert property ($past(sys_rst) |-> openDrainOe == 4'h0 && irqIoOe == 4'h0 && bidirOe == 8'h00 && analogSelect == 6'h00)
    else $error("pin state wrong after reset");
endmodule // port_pin_monitor

bind port_pin_control port_pin_monitor i_mon (.*);

// [test/port_board_model.sv]
// Board-side model: hold switch, pull-ups, interrupt sources, A/D core.
// Assumes the bench asks for pin levels; pads follow the block's enables.
`timescale 1ns/1ps
module port_board_model #(
  parameter int DONE_DLY = 4
) (
  input wire logic clk,
  input wire logic holdReq,
  input wire logic [5:0] anaReq,
  input wire logic [3:0] irqReq,
  input wire logic [7:0] bidReq,
  input wire logic adcStart,
  input wire logic [3:0] openDrainOe,
  input wire logic [3:0] irqIoOut,
  input wire logic [3:0] irqIoOe,
  input wire logic [7:0] bidirOut,
  input wire logic [7:0] bidirOe,
  output logic holdPin,
  output logic [5:0] analogPinIn,
  output logic [3:0] irqIoIn,
  output logic [7:0] bidirIn,
  output logic [3:0] odPad,
  output logic adcDone
);
  int cnt = 0;
  // Switch held low before a stop is asked for, high to leave it
  assign holdPin = holdReq;
  assign analogPinIn = anaReq;
  // Pull-up wins whenever the transistor is off
  assign odPad = ~openDrainOe;
  // Source yields where the block drives, so no contention is modelled
  assign irqIoIn = (irqIoOe & irqIoOut) | (~irqIoOe & irqReq);
  assign bidirIn = (bidirOe & bidirOut) | (~bidirOe & bidReq);
  initial adcDone = 1'h0;
  always @(posedge clk)
  begin
    adcDone <= (cnt == 1);
    if (adcStart)
      cnt <= DONE_DLY;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule // port_board_model

// [test/port_pin_control_tb.sv]
// Self-checking bench for the port pin control block.
// Assumes the board model supplies the pads and the A/D answer.
`timescale 1ns/1ps
module port_pin_control_tb;
  import port_pin_pkg::*;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [ADDR_W-1:0] regAddr = 5'h00;
  logic [DATA_W-1:0] regWdata = 8'h00;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic pllFmIn = 1'h1;
  logic pllAmIn = 1'h1;
  logic pllErrIn = 1'h1;
  logic holdReq = 1'h1;
  logic [5:0] anaReq = 6'h3F;
  logic [3:0] irqReq = 4'h0;
  logic [7:0] bidReq = 8'h3C;
  logic [DATA_W-1:0] regRdata;
  logic irq, holdPin, pllFmGated, pllAmGated, pllErrOut, pllErrOe, adcStart, adcDone, clockStopped;
  logic [5:0] analogPinIn, analogSelect;
  logic [2:0] adcChannel;
  logic [3:0] openDrainOut, openDrainOe, irqIoIn, irqIoOut, irqIoOe, odPad;
  logic [7:0] bidirIn, bidirOut, bidirOe;
  int numErrors = 0;
  int nTests = 0;
  int cycles = 0;

  port_pin_control i_dut (.*);
  port_board_model i_board (.*);

  initial
    forever #25 clk = ~clk;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdChk(input string what, input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1 chk(what, regRdata, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic testReset();
    #1;
    chk("odOe", {4'h0, openDrainOe}, 8'h00);
    chk("irqIoOe", {4'h0, irqIoOe}, 8'h00);
    chk("bidirOe", bidirOe, 8'h00);
    chk("anaSel", {2'h0, analogSelect}, 8'h00);
    chk("odOut", {4'h0, openDrainOut}, 8'h00);
    rdChk("odData", OFS_OD_DATA, 8'h0F);
    $display("test reset done");
  endtask

  task automatic testPorts();
    wr(OFS_IRQIO_DIR, 8'h0C);
    wr(OFS_IRQIO_DATA, 8'h04);
    wr(OFS_BIDIR_DIR, 8'hA5);
    wr(OFS_BIDIR_DATA, 8'hFF);
    wr(OFS_OD_DATA, 8'h06);
    chk("irqIoOe", {4'h0, irqIoOe}, 8'h0C);
    chk("irqIoOut", {4'h0, irqIoOut}, 8'h04);
    chk("bidirOe", bidirOe, 8'hA5);
    chk("odPad", {4'h0, odPad}, 8'h06);
    cyc(3);
    rdChk("bidirIn", OFS_BIDIR_IN, 8'hBD);
    rdChk("unmapped", 5'h1F, 8'h00);
    $display("test ports done");
  endtask

  task automatic testAnalog();
    wr(OFS_ANALOG_SEL, 8'h05);
    chk("anaSel", {2'h0, analogSelect}, 8'h05);
    rdChk("sharedIn", OFS_SHARED_IN, 8'h3A);
    wr(OFS_ADC_CH, 8'h05);
    chk("adcCh", {5'h00, adcChannel}, 8'h05);
    wr(OFS_CMD, 8'h04);
    chk("adcStart", {7'h00, adcStart}, 8'h01);
    cyc(8);
    rdChk("state", OFS_STATE, 8'h0A);
    rdChk("status", OFS_IRQ_STATUS, 8'h04);
    wr(OFS_IRQ_CLEAR, 8'h04);
    $display("test analog done");
  endtask

  task automatic testIrq();
    wr(OFS_CTRL, 8'h0C);
    wr(OFS_EDGE_SEL, 8'h02);
    wr(OFS_IRQ_ENABLE, 8'h03);
    @(posedge clk) irqReq <= 4'h3;
    cyc(5);
    rdChk("status", OFS_IRQ_STATUS, 8'h01);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(OFS_CTRL, 8'h0E);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(OFS_IRQ_CLEAR, 8'h01);
    cyc(4);
    rdChk("status", OFS_IRQ_STATUS, 8'h00);
    @(posedge clk) irqReq <= 4'h0;
    cyc(5);
    rdChk("status", OFS_IRQ_STATUS, 8'h02);
    wr(OFS_IRQ_ENABLE, 8'h01);
    chk("irq", {7'h00, irq}, 8'h00);
    wr(OFS_IRQ_CLEAR, 8'h02);
    wr(OFS_CTRL, 8'h00);
    $display("test irq done");
  endtask

  task automatic testHold();
    // One PLL input low so the gate is seen to pass the level, not a constant
    @(posedge clk) pllAmIn <= 1'h0;
    wr(OFS_CMD, 8'h01);
    chk("stopped", {7'h00, clockStopped}, 8'h00);
    wr(OFS_CTRL, 8'h01);
    chk("pll", {4'h0, pllFmGated, pllAmGated, pllErrOe, pllErrOut}, 8'h0B);
    @(posedge clk) holdReq <= 1'h0;
    cyc(4);
    chk("pll", {4'h0, pllFmGated, pllAmGated, pllErrOe, pllErrOut}, 8'h01);
    wr(OFS_CMD, 8'h01);
    chk("stopped", {7'h00, clockStopped}, 8'h01);
    chk("odOe", {4'h0, openDrainOe}, 8'h00);
    chk("irqIoOe", {4'h0, irqIoOe}, 8'h00);
    chk("bidirOe", bidirOe, 8'h00);
    rdChk("sharedIn", OFS_SHARED_IN, 8'h00);
    rdChk("bidirIn", OFS_BIDIR_IN, 8'h00);
    wr(OFS_CMD, 8'h04);
    chk("adcStart", {7'h00, adcStart}, 8'h00);
    @(posedge clk) holdReq <= 1'h1;
    cyc(3);
    chk("stopped", {7'h00, clockStopped}, 8'h00);
    chk("bidirOe", bidirOe, 8'hA5);
    $display("test hold done");
  endtask

  // Reset after ports were configured must bring the pin enables and analog selects back to their defaults
  task automatic testMidReset();
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clk);
    testReset();
    $display("test mid reset done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      numErrors++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clk);
    testReset();
    testPorts();
    testAnalog();
    testIrq();
    testHold();
    testMidReset();
    give_verdict();
  end
endmodule // port_pin_control_tb
